/* rtl/edif_pkg.sv */
// Package: register map, field layout and carrier types of the expansion input flags
package edif_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 32;
	localparam logic [15:0] ADDR_SECOND     = 16'h00ff;
	localparam logic [15:0] ADDR_LOWER      = 16'h116a;
	localparam logic [15:0] ADDR_UPPER      = 16'h116b;

	// ****************************************************************
	// Field layout
	// ****************************************************************
	localparam int          N_INPUTS        = 64;
	localparam int          N_MODULES       = 3;
	localparam int          WORD_W          = 16;
	localparam int          LOWER_LSB       = 0;
	localparam int          UPPER_LSB       = 16;
	localparam int          SECOND_LSB      = 32;
	localparam int          SECOND_W        = 32;
	localparam int          FIRST_MOD       = 0;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [31:0] RDATA_RST       = 32'h0000_0000;
	localparam logic [63:0] FLAGS_RST       = 64'h0000_0000_0000_0000;
	localparam logic [2:0]  PRES_RST        = 3'h0;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [15:0]       addr;
		logic [31:0]       wdata;
	} edif_req_s;

	typedef struct packed {
		logic              rvalid;
		logic              miss;
		logic              wr_ign;
		logic [31:0]       rdata;
	} edif_rsp_s;

endpackage : edif_pkg

/* rtl/edif_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module edif_sync #(
	parameter int W = 8
) (
	input  wire logic         i_mclk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_q
);
	import edif_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} edif_sync_s;

	edif_sync_s st;
	edif_sync_s next_st;

	// ****************************************************************
	// Filter: a bit changes once stages two and three agree
	// ****************************************************************
	always_comb begin
		next_st    = st;
		next_st.s1 = i_pin;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int b = 0; b < W; b++) begin
			if (st.s2[b] == st.s3[b]) begin
				next_st.q[b] = st.s3[b];
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_q = st.q;

endmodule : edif_sync

/* rtl/edif_top.sv */
// Expansion digital input flag registers, read-only, with pin synchronisers
//
// Overview of operation
// - A 16-bit read-only upper word reports digital inputs 17 to 32.
// - Upper word bit 0 is input 17, rising to bit 15 as input 32.
// - Each flag reads 1 for an active input and 0 for inactive.
// - Upper word shows real inputs only with at least one module attached.
// - A second 32-bit read-only register packs inputs 33 onward as flags.
// - Second register bit 0 is input 33, rising so bit 16 is input 49.
// - Second register shows valid inputs only when three modules are connected.
// - Lower word bits 4 to 6 report inputs 5 to 7 of first module.
// - Lower word bits 7 to 15 carry inputs 8 to 16 in order.
// - A 16-bit read-only lower word reports digital inputs 1 to 16.
`timescale 1ns/10ps
module edif_top (
	input  wire logic                          i_mclk,
	input  wire logic                          i_rst,
	input  wire logic [edif_pkg::N_INPUTS-1:0]  i_din,
	input  wire logic [edif_pkg::N_MODULES-1:0] i_mod_present,
	input  wire edif_pkg::edif_req_s           i_req,
	output edif_pkg::edif_rsp_s                o_rsp
);
	import edif_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		edif_rsp_s rsp;
	} edif_state_s;

	edif_state_s              st;
	edif_state_s              next_st;
	logic [N_INPUTS-1:0]      flags;
	logic [N_MODULES-1:0]     pres;
	logic                     any_mod;
	logic                     all_mod;
	logic                     first_mod;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	edif_sync #(
		.W      (N_INPUTS)
	) u_din_sync (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_pin  (i_din),
		.o_q    (flags)
	);

	edif_sync #(
		.W      (N_MODULES)
	) u_pres_sync (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_pin  (i_mod_present),
		.o_q    (pres)
	);

	assign any_mod   = |pres;
	assign all_mod   = &pres;
	assign first_mod = pres[FIRST_MOD];

	// ****************************************************************
	// Word views
	// ****************************************************************
	function automatic logic [31:0] word16(input logic [N_INPUTS-1:0] f,
	                                       input int                  lsb,
	                                       input logic                ok);
		logic [31:0] w;
		w = RDATA_RST;
		if (ok) begin
			w[WORD_W-1:0] = f[lsb +: WORD_W];
		end
		return w;
	endfunction : word16

	// ****************************************************************
	// Address decode
	// ****************************************************************
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return (a == ADDR_LOWER) || (a == ADDR_UPPER) || (a == ADDR_SECOND);
	endfunction : is_mapped

	// ****************************************************************
	// Register read decode
	// ****************************************************************
	always_comb begin
		next_st            = st;
		next_st.rsp.rvalid = 1'b0;
		next_st.rsp.miss   = 1'b0;
		// Writes without a read are acknowledged and dropped
		next_st.rsp.wr_ign = i_req.wr && !i_req.rd;
		if (i_req.rd) begin
			next_st.rsp.rvalid = 1'b1;
			case (i_req.addr)
				ADDR_LOWER: begin
					// Flag 1 per active input, from first module
					next_st.rsp.rdata = word16(flags, LOWER_LSB, first_mod);
				end
				ADDR_UPPER: begin
					next_st.rsp.rdata = word16(flags, UPPER_LSB, any_mod);
				end
				ADDR_SECOND: begin
					if (all_mod) begin
						next_st.rsp.rdata = flags[SECOND_LSB +: SECOND_W];
					end else begin
						next_st.rsp.rdata = RDATA_RST;
					end
				end
				default: begin
					next_st.rsp.rdata = RDATA_RST;
					next_st.rsp.miss  = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st.rsp.rvalid <= 1'b0;
			st.rsp.miss   <= 1'b0;
			st.rsp.wr_ign <= 1'b0;
			st.rsp.rdata  <= RDATA_RST;
		end else begin
			st <= next_st;
		end
	end

	assign o_rsp = st.rsp;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	upper_read_a: assert property (
		(i_req.rd && i_req.addr == ADDR_UPPER && any_mod)
		|=> o_rsp.rvalid && o_rsp.rdata[31:16] == 16'h0000
		 && o_rsp.rdata[15:0] == $past(flags[31:16]))
		else $error("upper word does not show inputs 17 to 32");

	upper_order_a: assert property (
		(i_req.rd && i_req.addr == ADDR_UPPER && any_mod)
		|=> o_rsp.rdata[0] == $past(flags[16]) && o_rsp.rdata[15] == $past(flags[31]))
		else $error("upper word bit order wrong");

	upper_gate_a: assert property (
		(i_req.rd && i_req.addr == ADDR_UPPER && !any_mod)
		|=> o_rsp.rvalid && o_rsp.rdata == 32'h0000_0000)
		else $error("upper word not blanked without a module");

	flag_level_a: assert property (
		($stable(i_din) && $stable(i_mod_present)) [*7]
		|-> flags == i_din && pres == i_mod_present)
		else $error("settled input does not read at its level");

	second_read_a: assert property (
		(i_req.rd && i_req.addr == ADDR_SECOND && all_mod)
		|=> o_rsp.rvalid && o_rsp.rdata == $past(flags[63:32]))
		else $error("second register does not show inputs 33 onward");

	second_order_a: assert property (
		(i_req.rd && i_req.addr == ADDR_SECOND && all_mod)
		|=> o_rsp.rdata[0] == $past(flags[32]) && o_rsp.rdata[16] == $past(flags[48]))
		else $error("second register bit order wrong");

	second_gate_a: assert property (
		(i_req.rd && i_req.addr == ADDR_SECOND && !all_mod)
		|=> o_rsp.rvalid && o_rsp.rdata == 32'h0000_0000)
		else $error("second register not blanked without three modules");

	lower_mid_a: assert property (
		(i_req.rd && i_req.addr == ADDR_LOWER && first_mod)
		|=> o_rsp.rdata[6:4] == $past(flags[6:4]))
		else $error("lower word bits 4 to 6 wrong");

	lower_top_a: assert property (
		(i_req.rd && i_req.addr == ADDR_LOWER && first_mod)
		|=> o_rsp.rdata[15:7] == $past(flags[15:7]))
		else $error("lower word bits 7 to 15 wrong");

	lower_word_a: assert property (
		(i_req.rd && i_req.addr == ADDR_LOWER)
		|=> o_rsp.rvalid && o_rsp.rdata[31:16] == 16'h0000
		 && o_rsp.rdata[3:0] == ($past(first_mod) ? $past(flags[3:0]) : 4'h0))
		else $error("lower word malformed");

	write_drop_a: assert property (
		(i_req.wr && !i_req.rd)
		|=> !o_rsp.rvalid && o_rsp.wr_ign && $stable(o_rsp.rdata))
		else $error("write was not ignored");

	miss_read_a: assert property (
		(i_req.rd && i_req.addr != ADDR_LOWER && i_req.addr != ADDR_UPPER
		 && i_req.addr != ADDR_SECOND)
		|=> o_rsp.miss && o_rsp.rdata == 32'h0000_0000)
		else $error("unmapped read not flagged");

	read_answer_a: assert property (
		i_req.rd
		|=> o_rsp.rvalid && !o_rsp.wr_ign)
		else $error("read not answered in the next cycle");

	idle_quiet_a: assert property (
		!i_req.rd
		|=> !o_rsp.rvalid && !o_rsp.miss)
		else $error("read answer without a read");

	miss_pair_a: assert property (
		o_rsp.miss
		|-> o_rsp.rvalid)
		else $error("miss raised without read answer");

	idle_hold_a: assert property (
		!i_req.rd
		|=> $stable(o_rsp.rdata))
		else $error("read data moved without a read");

	both_read_a: assert property (
		(i_req.rd && i_req.wr)
		|=> o_rsp.rvalid && !o_rsp.wr_ign)
		else $error("read with write not served as read");

	upper_hit_a: assert property (
		(i_req.rd && i_req.addr == ADDR_UPPER)
		|=> !o_rsp.miss)
		else $error("upper word read flagged as miss");

	second_hit_a: assert property (
		(i_req.rd && i_req.addr == ADDR_SECOND)
		|=> !o_rsp.miss)
		else $error("second register read flagged as miss");

	lower_hit_a: assert property (
		(i_req.rd && i_req.addr == ADDR_LOWER)
		|=> !o_rsp.miss)
		else $error("lower word read flagged as miss");

	upper_top_a: assert property (
		(i_req.rd && i_req.addr == ADDR_UPPER)
		|=> o_rsp.rdata[31:16] == 16'h0000)
		else $error("upper word high half not zero");

	lower_gate_a: assert property (
		(i_req.rd && i_req.addr == ADDR_LOWER && !first_mod)
		|=> o_rsp.rdata == 32'h0000_0000)
		else $error("lower word not blanked without first module");

	mapped_ok_a: assert property (
		(i_req.rd && is_mapped(i_req.addr))
		|=> !o_rsp.miss)
		else $error("mapped read flagged as miss");

	write_silent_a: assert property (
		(i_req.wr && !i_req.rd)
		|=> !o_rsp.miss)
		else $error("write raised a miss");

	wr_pulse_a: assert property (
		!(i_req.wr && !i_req.rd)
		|=> !o_rsp.wr_ign)
		else $error("write ignore pulse without a write");

	reset_clear_a: assert property (disable iff (1'b0)
		i_rst
		|=> o_rsp == '0)
		else $error("response not cleared by reset");

	pin_delay_a: assert property (
		!$past(i_rst)
		|-> ((flags ^ $past(flags)) & (flags ^ $past(i_din, 4))) == '0)
		else $error("input flag took a value other than its pin");

	pres_delay_a: assert property (
		!$past(i_rst)
		|-> ((pres ^ $past(pres)) & (pres ^ $past(i_mod_present, 4))) == '0)
		else $error("module flag took a value other than its pin");

	// ****************************************************************
	// Covers
	// ****************************************************************

	miss_cov_c: cover property (
		i_req.rd && !is_mapped(i_req.addr) ##1 o_rsp.miss);

	upper_cov_c: cover property (
		i_req.rd && i_req.addr == ADDR_UPPER && any_mod ##1 o_rsp.rdata != 32'h0000_0000);

	second_cov_c: cover property (
		i_req.rd && i_req.addr == ADDR_SECOND && all_mod ##1 o_rsp.rdata[16]);

	lower_cov_c: cover property (
		i_req.rd && i_req.addr == ADDR_LOWER && first_mod ##1 o_rsp.rdata[15]);

	write_cov_c: cover property (
		i_req.wr && !i_req.rd ##1 o_rsp.wr_ign);

endmodule : edif_top

/* tb/edif_exp_model.sv */
// Expansion module model: drives input pins and presence lines
`timescale 1ns/10ps
module edif_exp_model (
	input  wire logic [edif_pkg::N_INPUTS-1:0]  i_pattern,
	input  wire logic [edif_pkg::N_MODULES-1:0] i_present,
	input  wire logic                           i_mclk,
	output logic      [edif_pkg::N_INPUTS-1:0]  o_din         = '0,
	output logic      [edif_pkg::N_MODULES-1:0] o_mod_present = '0
);
	import edif_pkg::*;
	// Lines float to junk when nothing is plugged in
	always @(negedge i_mclk) begin
		o_din         <= (|i_present) ? i_pattern : ~i_pattern;
		o_mod_present <= i_present;
	end
endmodule : edif_exp_model

/* tb/testbench.sv */
// Self-checking bench for the expansion input flag registers
`timescale 1ns/10ps
module testbench;
	import edif_pkg::*;
	typedef struct packed {
		logic [2:0]  pres;
		logic        inv;
		logic [15:0] addr;
		logic [31:0] want;
		logic        miss;
	} edif_row_s;
	localparam logic [63:0] PAT = 64'h8001_a5c3_0001_8070;
	logic        i_mclk     = 1'b0;
	logic        i_rst      = 1'b1;
	logic [63:0] pattern    = PAT;
	logic [2:0]  present    = 3'h0;
	logic [63:0] din;
	logic [2:0]  modp;
	edif_req_s   req        = '0;
	edif_rsp_s   rsp;
	int          n_mismatch = 0;
	int          n_checks   = 0;
	edif_row_s   rows [12]  = '{
		'{3'h7, 1'h0, ADDR_SECOND, 32'h8001_a5c3, 1'h0},
		'{3'h7, 1'h0, ADDR_LOWER,  32'h0000_8070, 1'h0},
		'{3'h7, 1'h0, ADDR_UPPER,  32'h0000_0001, 1'h0},
		'{3'h7, 1'h1, ADDR_SECOND, 32'h7ffe_5a3c, 1'h0},
		'{3'h7, 1'h1, ADDR_UPPER,  32'h0000_fffe, 1'h0},
		'{3'h1, 1'h0, ADDR_LOWER,  32'h0000_8070, 1'h0},
		'{3'h1, 1'h0, ADDR_SECOND, 32'h0000_0000, 1'h0},
		'{3'h2, 1'h0, ADDR_LOWER,  32'h0000_0000, 1'h0},
		'{3'h2, 1'h0, ADDR_UPPER,  32'h0000_0001, 1'h0},
		'{3'h0, 1'h0, ADDR_UPPER,  32'h0000_0000, 1'h0},
		'{3'h6, 1'h0, ADDR_SECOND, 32'h0000_0000, 1'h0},
		'{3'h7, 1'h0, 16'h0100,    32'h0000_0000, 1'h1}
	};

	always #25 i_mclk = ~i_mclk;

	edif_exp_model u_model (.i_pattern(pattern), .i_present(present), .i_mclk(i_mclk),
		.o_din(din), .o_mod_present(modp));
	edif_top u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_din(din), .i_mod_present(modp),
		.i_req(req), .o_rsp(rsp));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : cmp

	// Request held one full cycle; answer sampled at the following falling edge
	task bus(input logic rd, input logic wr, input logic [15:0] addr);
		req = '{rd, wr, addr, 32'hffff_ffff};
		@(negedge i_mclk);
	endtask : bus

	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		repeat (2000) @(posedge i_mclk);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		repeat (8) @(negedge i_mclk);
		i_rst = 1'b0;
		foreach (rows[i]) begin
			present = rows[i].pres;
			pattern = rows[i].inv ? ~PAT : PAT;
			repeat (6) @(negedge i_mclk);
			bus(1'b1, 1'b0, rows[i].addr);
			cmp("rdata", rows[i].want, rsp.rdata);
			cmp("rvalid", 32'h0000_0001, {31'h0, rsp.rvalid});
			cmp("miss", {31'h0, rows[i].miss}, {31'h0, rsp.miss});
		end
		bus(1'b1, 1'b0, ADDR_UPPER);
		bus(1'b0, 1'b1, ADDR_UPPER);
		cmp("wr_ign", 32'h0000_0001, {31'h0, rsp.wr_ign});
		cmp("rvalid", 32'h0000_0000, {31'h0, rsp.rvalid});
		cmp("rdata", 32'h0000_0001, rsp.rdata);
		bus(1'b1, 1'b1, ADDR_SECOND);
		cmp("rdata", 32'h8001_a5c3, rsp.rdata);
		cmp("wr_ign", 32'h0000_0000, {31'h0, rsp.wr_ign});
		bus(1'b1, 1'b0, ADDR_LOWER);
		cmp("rdata", 32'h0000_8070, rsp.rdata);
		i_rst = 1'b1;
		bus(1'b1, 1'b0, ADDR_UPPER);
		cmp("rsp", 32'h0000_0000, rsp.rdata);
		cmp("flags", 32'h0000_0000, {29'h0, rsp.rvalid, rsp.miss, rsp.wr_ign});
		i_rst = 1'b0;
		bus(1'b0, 1'b0, ADDR_UPPER);
		repeat (6) @(negedge i_mclk);
		bus(1'b1, 1'b0, ADDR_UPPER);
		cmp("rdata", 32'h0000_0001, rsp.rdata);
		bus(1'b0, 1'b0, ADDR_UPPER);
		cmp("rvalid", 32'h0000_0000, {31'h0, rsp.rvalid});
		give_verdict();
	end
endmodule : testbench
